// ---- rtl/edge_sync3.v ----
// three-stage input synchroniser with rising edge pulse per bit
`timescale 1ns/100ps
module edge_sync3 #(
   parameter WIDTH = 2
) (
   input  wire             clk_sys,
   input  wire             nrst,
   input  wire [WIDTH-1:0] asyncIn,
   output wire [WIDTH-1:0] risePulse
);
   // ==================================================
   // per-bit chain; edge seen when stages 2 and 3 agree high while the held level is still low
   genvar i;
   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : g_sync
         reg [2:0] stage_reg;
         reg       level_reg;
         always @(posedge clk_sys or negedge nrst) begin
            if (!nrst) begin
               stage_reg <= 3'h0;
               level_reg <= 1'h0;
            end else begin
               stage_reg <= {stage_reg[1:0], asyncIn[i]};
               if (stage_reg[1] == stage_reg[2])
                  level_reg <= stage_reg[2];
            end
         end
         assign risePulse[i] = (stage_reg[1] == stage_reg[2]) && stage_reg[2] && !level_reg;
      end
   endgenerate
endmodule

// ---- rtl/prio_irq_defs.vh ----
// constants for the prioritised interrupt control block
`ifndef PRIO_IRQ_DEFS_VH
`define PRIO_IRQ_DEFS_VH
// ==================================================
// control word addresses
`define ADDR_WORD0      2'h0
`define ADDR_WORD1      2'h1
`define ADDR_WORD2      2'h2
`define ADDR_WORD3      2'h3
// ==================================================
// bit positions
`define W0_GIE          0
`define W0_EXT0_FLAG    2
`define W0_EXT0_MASK    3
`define W1_EXT1_FLAG    0
`define W1_EXT1_MASK    1
`define W1_TMRA_FLAG    2
`define W1_TMRA_MASK    3
`define W2_TMRB_FLAG    0
`define W2_TMRB_MASK    1
`define W2_TMRC_FLAG    2
`define W2_TMRC_MASK    3
`define W3_AD_FLAG      0
`define W3_AD_MASK      1
`define W3_SER_FLAG     2
`define W3_SER_MASK     3
// ==================================================
// source indices, priority order
`define SRC_EXT0        0
`define SRC_EXT1        1
`define SRC_TMRA        2
`define SRC_TMRB        3
`define SRC_TMRC        4
`define SRC_AD          5
`define SRC_SER         6
`define NUM_SRC         7
// ==================================================
// vector addresses
`define VEC_RESET_STOP_CANCEL_IN 4'h0
`define VEC_STEP        4'h2
// ==================================================
// acknowledge sequence states
`define SEQ_IDLE        2'h0
`define SEQ_CYC1        2'h1
`define SEQ_CYC2        2'h2
`define SEQ_CYC3        2'h3
// ==================================================
// reset values
`define MASK_RESET      7'h7f
`define FLAG_RESET      7'h00
`define GIE_RESET       1'h0
// ==================================================
// pin synchroniser lanes
`define PIN_EXT0        0
`define PIN_EXT1        1
`define PIN_STOP_CANCEL_IN       2
`define PIN_COUNT       3
`endif

// ---- rtl/prioritised_interrupt_control.v ----
// interrupt flags, masks, priority select and acknowledge sequencing
`timescale 1ns/100ps
`include "prio_irq_defs.vh"
// Overview of operation
// - take irq only with global enable, flag set, mask clear; fixed priority order
// - lower-priority flags and masks never affect the selected source
// - global enable is bit 0 of word zero; 0 blocks all sources
// - enable cleared when interrupt processed, set by return-from-interrupt
// - external flags set on rising input edge, word0 bit2 and word1 bit0
// - external masks at word0 bit3 and word1 bit1; 1 blocks
// - timer A flag, word1 bit2, set by timer A overflow
// - timer A mask, word1 bit3, 1 blocks
// - timer B flag, word2 bit0, set by timer B overflow
// - timer B mask, word2 bit1, 1 blocks
// - timer C flag, word2 bit2, set by timer C overflow
// - stop-cancel request taken only while in stop mode
// - timer C mask, word2 bit3, 1 blocks
// - software never sets a flag; reset clears enable, flags, sets masks
// - after ack: cycle1 finish, cycle2 clear enable, cycles2-3 push, cycle3 jump
module prioritised_interrupt_control (
   input  wire       clk_sys,
   input  wire       nrst,
   input  wire       ext_irq_in0,
   input  wire       ext_irq_in1,
   input  wire       stop_cancel_in,
   input  wire       tmraOverflow,
   input  wire       tmrbOverflow,
   input  wire       tmrcOverflow,
   input  wire       adDone,
   input  wire       serialDone,
   input  wire       stopMode,
   input  wire       return_from_irq_instr,
   input  wire       ackTake,
   input  wire [1:0] wordAddr,
   input  wire       wordWrite,
   input  wire [3:0] wordWdata,
   output reg  [3:0] wordRdata,
   output wire       irqRequest,
   output wire       stopCancelRequest,
   output reg  [3:0] vectorAddr,
   output wire       finishCycle,
   output wire       pushCycle,
   output wire       jumpCycle
);
   // ==================================================
   // pin synchronisers and edge detect
   // all pins share one synchroniser, one lane per pin index
   wire [`PIN_COUNT-1:0] pinRise;
   edge_sync3 #(
      .WIDTH (`PIN_COUNT)
   ) u_sync (
      .clk_sys   (clk_sys),
      .nrst      (nrst),
      .asyncIn   ({stop_cancel_in, ext_irq_in1, ext_irq_in0}),
      .risePulse (pinRise)
   );

   // ==================================================
   // flag set and clear
   reg  [`NUM_SRC-1:0] flag_reg;
   reg  [`NUM_SRC-1:0] flag_next;
   reg  [`NUM_SRC-1:0] mask_reg;
   reg  [`NUM_SRC-1:0] mask_next;
   reg                 gie_reg;
   reg                 gie_next;
   reg  [1:0]          seq_reg;
   reg  [1:0]          seq_next;
   reg  [3:0]          vec_next;
   wire [`NUM_SRC-1:0] setEvt;
   wire [`NUM_SRC-1:0] swClr;
   wire [`NUM_SRC-1:0] active;
   wire [`NUM_SRC-1:0] higherActive;
   wire [`NUM_SRC-1:0] winner;
   wire                wr0 = wordWrite && (wordAddr == `ADDR_WORD0);
   wire                wr1 = wordWrite && (wordAddr == `ADDR_WORD1);
   wire                wr2 = wordWrite && (wordAddr == `ADDR_WORD2);
   wire                wr3 = wordWrite && (wordAddr == `ADDR_WORD3);

   // timer, converter and serial pulses share this clock and need no sync
   assign setEvt[`SRC_EXT0] = pinRise[`PIN_EXT0];
   assign setEvt[`SRC_EXT1] = pinRise[`PIN_EXT1];
   assign setEvt[`SRC_TMRA] = tmraOverflow;
   assign setEvt[`SRC_TMRB] = tmrbOverflow;
   assign setEvt[`SRC_TMRC] = tmrcOverflow;
   assign setEvt[`SRC_AD]   = adDone;
   assign setEvt[`SRC_SER]  = serialDone;

   // a write of 0 clears; a write of 1 leaves the flag alone
   assign swClr[`SRC_EXT0] = wr0 && !wordWdata[`W0_EXT0_FLAG];
   assign swClr[`SRC_EXT1] = wr1 && !wordWdata[`W1_EXT1_FLAG];
   assign swClr[`SRC_TMRA] = wr1 && !wordWdata[`W1_TMRA_FLAG];
   assign swClr[`SRC_TMRB] = wr2 && !wordWdata[`W2_TMRB_FLAG];
   assign swClr[`SRC_TMRC] = wr2 && !wordWdata[`W2_TMRC_FLAG];
   assign swClr[`SRC_AD]   = wr3 && !wordWdata[`W3_AD_FLAG];
   assign swClr[`SRC_SER]  = wr3 && !wordWdata[`W3_SER_FLAG];

   always @* begin
      // set wins over clear; mask and enable do not touch flags
      flag_next = (flag_reg & ~swClr) | setEvt;
      mask_next = mask_reg;
      if (wr0)
         mask_next[`SRC_EXT0] = wordWdata[`W0_EXT0_MASK];
      if (wr1) begin
         mask_next[`SRC_EXT1] = wordWdata[`W1_EXT1_MASK];
         mask_next[`SRC_TMRA] = wordWdata[`W1_TMRA_MASK];
      end
      if (wr2) begin
         mask_next[`SRC_TMRB] = wordWdata[`W2_TMRB_MASK];
         mask_next[`SRC_TMRC] = wordWdata[`W2_TMRC_MASK];
      end
      if (wr3) begin
         mask_next[`SRC_AD]  = wordWdata[`W3_AD_MASK];
         mask_next[`SRC_SER] = wordWdata[`W3_SER_MASK];
      end
   end

   // ==================================================
   // priority selection
   assign active     = flag_reg & ~mask_reg;
   assign irqRequest = gie_reg && (|active) && (seq_reg == `SEQ_IDLE);
   assign stopCancelRequest = pinRise[`PIN_STOP_CANCEL_IN] && stopMode;

   // a source wins only while every higher-priority source is idle
   genvar g;
   generate
      for (g = 0; g < `NUM_SRC; g = g + 1) begin : g_prio
         if (g == 0) begin : g_first
            assign higherActive[g] = 1'h0;
         end else begin : g_next
            assign higherActive[g] = higherActive[g-1] || active[g-1];
         end
      end
   endgenerate
   assign winner = active & ~higherActive;

   integer k;
   always @* begin
      // at most one winner bit is set, so loop order does not matter
      vec_next = vectorAddr;
      if (stopCancelRequest)
         vec_next = `VEC_RESET_STOP_CANCEL_IN;
      else if (irqRequest && ackTake) begin
         for (k = 0; k < `NUM_SRC; k = k + 1) begin
            if (winner[k])
               vec_next = `VEC_STEP + (`VEC_STEP * k[3:0]);
         end
      end
   end

   // ==================================================
   // acknowledge sequence and global enable
   // one acknowledge walks the three cycles, then the sequencer idles again
   always @* begin
      seq_next = seq_reg;
      gie_next = gie_reg;
      case (seq_reg)
         `SEQ_IDLE: begin
            if (irqRequest && ackTake)
               seq_next = `SEQ_CYC1;
         end
         `SEQ_CYC1: begin
            seq_next = `SEQ_CYC2;
         end
         `SEQ_CYC2: begin
            seq_next = `SEQ_CYC3;
            gie_next = 1'h0;
         end
         `SEQ_CYC3: begin
            seq_next = `SEQ_IDLE;
         end
         default: begin
            seq_next = `SEQ_IDLE;
         end
      endcase
      // enable writes in cycle two are dropped so the hardware clear sticks
      if (seq_reg != `SEQ_CYC2) begin
         if (wr0)
            gie_next = wordWdata[`W0_GIE];
         if (return_from_irq_instr)
            gie_next = 1'h1;
      end
   end

   assign finishCycle = (seq_reg == `SEQ_CYC1);
   assign pushCycle   = (seq_reg == `SEQ_CYC2) || (seq_reg == `SEQ_CYC3);
   assign jumpCycle   = (seq_reg == `SEQ_CYC3);

   // reset: enable off, every flag clear, every source masked
   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         flag_reg   <= `FLAG_RESET;
         mask_reg   <= `MASK_RESET;
         gie_reg    <= `GIE_RESET;
         seq_reg    <= `SEQ_IDLE;
         vectorAddr <= `VEC_RESET_STOP_CANCEL_IN;
      end else begin
         flag_reg   <= flag_next;
         mask_reg   <= mask_next;
         gie_reg    <= gie_next;
         seq_reg    <= seq_next;
         vectorAddr <= vec_next;
      end
   end

   // ==================================================
   // word read-back
   // bit 1 of word zero is unused and reads as zero
   always @* begin
      wordRdata = 4'h0;
      case (wordAddr)
         `ADDR_WORD0: wordRdata = {mask_reg[`SRC_EXT0], flag_reg[`SRC_EXT0], 1'h0, gie_reg};
         `ADDR_WORD1: wordRdata = {mask_reg[`SRC_TMRA], flag_reg[`SRC_TMRA],
                                   mask_reg[`SRC_EXT1], flag_reg[`SRC_EXT1]};
         `ADDR_WORD2: wordRdata = {mask_reg[`SRC_TMRC], flag_reg[`SRC_TMRC],
                                   mask_reg[`SRC_TMRB], flag_reg[`SRC_TMRB]};
         `ADDR_WORD3: wordRdata = {mask_reg[`SRC_SER], flag_reg[`SRC_SER],
                                   mask_reg[`SRC_AD], flag_reg[`SRC_AD]};
         default:     wordRdata = 4'h0;
      endcase
   end
endmodule

// ---- testbench/core_model.sv ----
// core sequencer model: accepts requests and returns from the handler
`timescale 1ns/100ps
module core_model #(
   parameter int RTI_DELAY = 8
) (
   input  wire logic clk_sys,
   input  wire logic nrst,
   input  wire logic irqRequest,
   input  wire logic jumpCycle,
   input  wire logic allowAck,
   output logic      ackTake,
   output logic      rtiPulse
);
   logic [3:0] cnt;
   // the bench stalls the core by holding allowAck low
   assign ackTake = irqRequest & allowAck;
   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         cnt <= 4'h0;
         rtiPulse <= 1'b0;
      end else begin
         rtiPulse <= (cnt == 4'h1);
         if (jumpCycle) begin
            cnt <= 4'(RTI_DELAY);
         end else if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
         end
      end
   end
endmodule

// ---- testbench/prio_irq_sva.sv ----
// assertion checker for the interrupt control block
`timescale 1ns/100ps
module prio_irq_sva (
   input wire logic       clk_sys,
   input wire logic       nrst,
   input wire logic       stopMode,
   input wire logic       return_from_irq_instr,
   input wire logic       ackTake,
   input wire logic [1:0] wordAddr,
   input wire logic       wordWrite,
   input wire logic [3:0] wordWdata,
   input wire logic [3:0] wordRdata,
   input wire logic       irqRequest,
   input wire logic       stopCancelRequest,
   input wire logic [3:0] vectorAddr,
   input wire logic       finishCycle,
   input wire logic       pushCycle,
   input wire logic       jumpCycle
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   // ==========
   // acknowledge sequence
   AST_ACK_FINISH: assert property (irqRequest && ackTake |=> finishCycle)
      else $error("no finish cycle");
   AST_SEQ_ORDER: assert property (finishCycle |=> pushCycle && !jumpCycle ##1
      pushCycle && jumpCycle ##1 !pushCycle) else $error("bad sequence");
   AST_VEC_EVEN: assert property (irqRequest && ackTake |=>
      vectorAddr != 4'h0 && !vectorAddr[0]) else $error("bad vector");
   AST_GIE_CLR: assert property (finishCycle |-> ##2
      (wordAddr != 2'h0 || !wordRdata[0])) else $error("enable kept");
   AST_RTI_SET: assert property (return_from_irq_instr && !wordWrite && !pushCycle |=>
      wordAddr != 2'h0 || wordRdata[0]) else $error("enable not set");
   // ==========
   // gating and flags
   AST_GIE_BLOCK: assert property (wordAddr == 2'h0 && !wordRdata[0] |->
      !irqRequest) else $error("request while disabled");
   AST_STOP_CANCEL_IN: assert property (stopCancelRequest |-> stopMode)
      else $error("stop cancel outside stop");
   AST_FLAG_HOLD: assert property (wordAddr == 2'h2 && wordRdata[0] &&
      !(wordWrite && !wordWdata[0]) |=> wordAddr != 2'h2 || wordRdata[0])
      else $error("flag lost");
endmodule
bind prioritised_interrupt_control prio_irq_sva chk (.clk_sys, .nrst, .stopMode,
   .return_from_irq_instr, .ackTake, .wordAddr, .wordWrite, .wordWdata, .wordRdata,
   .irqRequest, .stopCancelRequest, .vectorAddr, .finishCycle, .pushCycle, .jumpCycle);

// ---- testbench/test_prioritised_interrupt_control.sv ----
// self-checking bench for the interrupt control block
`timescale 1ns/100ps
module test_prioritised_interrupt_control;
   logic       clk_sys = 1'b0;
   logic       nrst = 1'b0;
   logic [7:0] srcIn = 8'h00;
   logic       stopMode = 1'b0;
   logic [1:0] wordAddr = 2'h0;
   logic       wordWrite = 1'b0;
   logic [3:0] wordWdata = 4'h0;
   logic       allowAck = 1'b0;
   wire        ackTake, rtiPulse, irqRequest, stopCancelRequest;
   wire        finishCycle, pushCycle, jumpCycle;
   wire  [3:0] wordRdata, vectorAddr;
   int         num_errors = 0;
   int         check_count = 0;
   always #12.5 clk_sys = ~clk_sys;
   prioritised_interrupt_control DUT (.clk_sys, .nrst, .ext_irq_in0(srcIn[0]),
      .ext_irq_in1(srcIn[1]), .tmraOverflow(srcIn[2]), .tmrbOverflow(srcIn[3]),
      .tmrcOverflow(srcIn[4]), .adDone(srcIn[5]), .serialDone(srcIn[6]),
      .stop_cancel_in(srcIn[7]), .stopMode, .return_from_irq_instr(rtiPulse), .ackTake,
      .wordAddr, .wordWrite, .wordWdata, .wordRdata, .irqRequest, .stopCancelRequest,
      .vectorAddr, .finishCycle, .pushCycle, .jumpCycle);
   core_model CORE (.clk_sys, .nrst, .irqRequest, .jumpCycle, .allowAck, .ackTake, .rtiPulse);
   // ==========
   // shared tasks
   task chk(input logic [3:0] got, input logic [3:0] exp);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   task wr(input logic [1:0] a, input logic [3:0] d);
      @(posedge clk_sys);
      wordAddr <= a;
      wordWrite <= 1'b1;
      wordWdata <= d;
      @(posedge clk_sys);
      wordWrite <= 1'b0;
   endtask
   task rd(input logic [1:0] a, input logic [3:0] e);
      @(posedge clk_sys);
      wordAddr <= a;
      @(negedge clk_sys);
      chk(wordRdata, e);
   endtask
   task fire(input logic [7:0] s);
      @(posedge clk_sys);
      srcIn <= s;
      repeat (2) @(posedge clk_sys);
      srcIn <= 8'h00;
      repeat (5) @(posedge clk_sys);
   endtask
   task waitJump;
      int i;
      i = 0;
      do @(negedge clk_sys); while (jumpCycle !== 1'b1 && ++i < 60);
      if (jumpCycle !== 1'b1) begin
         $display("BAD %0t no jump cycle", $time);
         num_errors++;
         tally_and_finish;
      end
   endtask
   task stopTry(input logic m, input logic [3:0] e);
      logic seen;
      seen = 1'b0;
      @(posedge clk_sys);
      stopMode <= m;
      srcIn <= 8'h80;
      repeat (8) begin
         @(negedge clk_sys);
         if (stopCancelRequest === 1'b1) seen = 1'b1;
      end
      @(posedge clk_sys);
      srcIn <= 8'h00;
      stopMode <= 1'b0;
      chk({3'h0, seen}, e);
      // hold the pin low long enough for the synchroniser to settle low
      repeat (4) @(posedge clk_sys);
   endtask
   task tally_and_finish;
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // ==========
   // scenarios
   task testReset;
      int a;
      for (a = 0; a < 4; a++) rd(a[1:0], (a == 0) ? 4'h8 : 4'ha);
      $display("done reset");
   endtask
   task testPriority;
      int s;
      for (s = 3; s >= 0; s--) wr(s[1:0], 4'h0);
      fire(8'h7f);
      rd(2'h0, 4'h4);
      rd(2'h1, 4'h5);
      rd(2'h2, 4'h5);
      wr(2'h0, 4'h5);
      allowAck <= 1'b1;
      for (s = 0; s < 7; s++) begin
         waitJump;
         chk(vectorAddr, 4'h2 + 4'(2 * s));
         chk({2'h0, pushCycle, finishCycle}, 4'h2);
         wr(2'((s + 1) / 2), s[0] ? 4'h4 : 4'h1);
      end
      allowAck <= 1'b0;
      rd(2'h0, 4'h0);
      repeat (12) @(posedge clk_sys);
      rd(2'h0, 4'h1);
      $display("done priority");
   endtask
   task testMask;
      wr(2'h1, 4'h8);
      wr(2'h0, 4'h9);
      fire(8'h04);
      rd(2'h1, 4'hc);
      chk({3'h0, irqRequest}, 4'h0);
      wr(2'h0, 4'h8);
      wr(2'h1, 4'h4);
      rd(2'h0, 4'h8);
      chk({3'h0, irqRequest}, 4'h0);
      wr(2'h0, 4'h9);
      rd(2'h0, 4'h9);
      chk({3'h0, irqRequest}, 4'h1);
      wr(2'h1, 4'h8);
      wr(2'h2, 4'h5);
      rd(2'h2, 4'h0);
      $display("done mask");
   endtask
   task testStop;
      stopTry(1'b0, 4'h0);
      stopTry(1'b1, 4'h1);
      chk(vectorAddr, 4'h0);
      $display("done stop");
   endtask
   initial begin
      repeat (5) @(posedge clk_sys);
      nrst <= 1'b1;
      testReset;
      testPriority;
      testMask;
      testStop;
      tally_and_finish;
   end
endmodule
